// [ccei_top.sv]
// Comparator control block: registers, input routing, output pin and edge interrupt
//
// Behaviour
// - Enable bit toggles module, other fields untouched
// - Pin drive enable puts result on pin
// - Invert bit inverts the comparator output
// - Read-only result bit shows comparator output
// - Edge select: 11 any, 10 fall, 01 rise
// - Edge select 00 raises no event
// - Inversion also feeds the edge detector
// - Positive select: 1 ladder reference, 0 pin A
// - Negative select: 11 bandgap, 10 D, 01 C, 00 B
// - Unimplemented control bits read as zero
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module ccei_top
  import ccei_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [CCEI_ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic analog_result_in,
  output logic analog_enable_out,
  output logic positive_input_select_out,
  output logic [1:0] negative_input_select_out,
  output logic compare_out_pin_out,
  output logic compare_out_pin_oe_out,
  output logic irq_event_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  ccei_bus_t bus;
  ccei_ctrl_t ctrl_reg;
  logic [31:0] rdata_reg;
  logic irq_status_reg;
  logic irq_mask_reg;
  logic irq_reg;
  logic pin_reg;
  logic pin_oe_reg;
  logic event_reg;
  logic level;
  logic event_pulse;
  logic [31:0] ctrl_view;

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ctrl_reg.enable <= CCEI_ENABLE_RST;
      ctrl_reg.pin_drive_enable <= CCEI_PIN_DRIVE_RST;
      ctrl_reg.output_invert <= CCEI_INVERT_RST;
      ctrl_reg.irq_edge_select <= CCEI_EDGE_SEL_RST;
      ctrl_reg.positive_input_select <= CCEI_POS_SEL_RST;
      ctrl_reg.negative_input_select <= CCEI_NEG_SEL_RST;
    end
    else if (bus.wr && bus.addr == CCEI_CTRL_ADDR)
    begin
      // Each field loads only itself
      ctrl_reg.enable <= bus.wdata[CCEI_ENABLE_BIT];
      ctrl_reg.pin_drive_enable <= bus.wdata[CCEI_PIN_DRIVE_BIT];
      ctrl_reg.output_invert <= bus.wdata[CCEI_INVERT_BIT];
      ctrl_reg.irq_edge_select <= bus.wdata[CCEI_EDGE_SEL_LSB +: 2];
      ctrl_reg.positive_input_select <= bus.wdata[CCEI_POS_SEL_BIT];
      ctrl_reg.negative_input_select <= bus.wdata[CCEI_NEG_SEL_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog core steering

  assign analog_enable_out = ctrl_reg.enable;
  assign positive_input_select_out = ctrl_reg.positive_input_select;
  assign negative_input_select_out = ctrl_reg.negative_input_select;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection

  ccei_edge_detect u_edge (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .raw_in(analog_result_in & ctrl_reg.enable),
    .invert_in(ctrl_reg.output_invert),
    .edge_select_in(ctrl_reg.irq_edge_select),
    .level_out(level),
    .event_out(event_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output pin

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pin_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end
    else
    begin
      pin_reg <= ctrl_reg.pin_drive_enable & level;
      pin_oe_reg <= ctrl_reg.pin_drive_enable;
    end
  end

  assign compare_out_pin_out = pin_reg;
  assign compare_out_pin_oe_out = pin_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      irq_status_reg <= 1'b0;
    end
    else if (event_pulse)
    begin
      irq_status_reg <= 1'b1;
    end
    else if (bus.wr && bus.addr == CCEI_IRQ_STATUS_ADDR && bus.wdata[0])
    begin
      irq_status_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      irq_mask_reg <= CCEI_IRQ_MASK_RST;
    end
    else if (bus.wr && bus.addr == CCEI_IRQ_MASK_ADDR)
    begin
      irq_mask_reg <= bus.wdata[0];
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      irq_reg <= 1'b0;
      event_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= (irq_status_reg | event_pulse) & irq_mask_reg;
      event_reg <= event_pulse;
    end
  end

  assign irq_out = irq_reg;
  assign irq_event_out = event_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb
  begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[CCEI_ENABLE_BIT] = ctrl_reg.enable;
    ctrl_view[CCEI_PIN_DRIVE_BIT] = ctrl_reg.pin_drive_enable;
    ctrl_view[CCEI_INVERT_BIT] = ctrl_reg.output_invert;
    ctrl_view[CCEI_RESULT_BIT] = level;
    ctrl_view[CCEI_EDGE_SEL_LSB +: 2] = ctrl_reg.irq_edge_select;
    ctrl_view[CCEI_POS_SEL_BIT] = ctrl_reg.positive_input_select;
    ctrl_view[CCEI_NEG_SEL_LSB +: 2] = ctrl_reg.negative_input_select;
  end

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rdata_reg <= 32'h0000_0000;
    end
    else if (bus.rd)
    begin
      unique case (bus.addr)
        CCEI_CTRL_ADDR: rdata_reg <= ctrl_view;
        CCEI_IRQ_STATUS_ADDR: rdata_reg <= {31'h0000_0000, irq_status_reg};
        CCEI_IRQ_MASK_ADDR: rdata_reg <= {31'h0000_0000, irq_mask_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
    else
    begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign rdata_out = rdata_reg;

endmodule // ccei_top

// [ccei_pkg.sv]
// Package: register map, field positions and reset values of the comparator control block
package ccei_pkg;

  // Register byte addresses
  localparam logic [7:0] CCEI_CTRL_ADDR = 8'h00;
  localparam logic [7:0] CCEI_IRQ_STATUS_ADDR = 8'h04;
  localparam logic [7:0] CCEI_IRQ_MASK_ADDR = 8'h08;
  localparam int CCEI_ADDR_W = 8;

  // Control register field positions
  localparam int CCEI_ENABLE_BIT = 15;
  localparam int CCEI_PIN_DRIVE_BIT = 14;
  localparam int CCEI_INVERT_BIT = 13;
  localparam int CCEI_RESULT_BIT = 8;
  localparam int CCEI_EDGE_SEL_LSB = 6;
  localparam int CCEI_POS_SEL_BIT = 4;
  localparam int CCEI_NEG_SEL_LSB = 0;

  // Edge select codes
  localparam logic [1:0] CCEI_EDGE_NONE = 2'h0;
  localparam logic [1:0] CCEI_EDGE_RISE = 2'h1;
  localparam logic [1:0] CCEI_EDGE_FALL = 2'h2;
  localparam logic [1:0] CCEI_EDGE_ANY = 2'h3;

  // Negative input codes
  localparam logic [1:0] CCEI_NEG_PIN_B = 2'h0;
  localparam logic [1:0] CCEI_NEG_PIN_C = 2'h1;
  localparam logic [1:0] CCEI_NEG_PIN_D = 2'h2;
  localparam logic [1:0] CCEI_NEG_BANDGAP = 2'h3;

  // Reset values
  localparam logic [1:0] CCEI_EDGE_SEL_RST = 2'h3;
  localparam logic [1:0] CCEI_NEG_SEL_RST = 2'h3;
  localparam logic CCEI_ENABLE_RST = 1'b0;
  localparam logic CCEI_PIN_DRIVE_RST = 1'b0;
  localparam logic CCEI_INVERT_RST = 1'b0;
  localparam logic CCEI_POS_SEL_RST = 1'b0;
  localparam logic CCEI_IRQ_MASK_RST = 1'b0;

  // Writable control fields
  typedef struct packed {
    logic enable;
    logic pin_drive_enable;
    logic output_invert;
    logic [1:0] irq_edge_select;
    logic positive_input_select;
    logic [1:0] negative_input_select;
  } ccei_ctrl_t;

  // Register bus request
  typedef struct packed {
    logic [CCEI_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ccei_bus_t;

endpackage

// [ccei_edge_detect.sv]
// Synchroniser and edge detector for the comparator output
`timescale 1ns/1ps
module ccei_edge_detect
  import ccei_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic raw_in,
  input wire logic invert_in,
  input wire logic [1:0] edge_select_in,
  output logic level_out,
  output logic event_out
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic event_reg;
  logic pol_level;
  logic rise;
  logic fall;

  // Two-stage synchroniser
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  assign pol_level = sync2_reg ^ invert_in;
  assign rise = pol_level & ~prev_reg;
  assign fall = ~pol_level & prev_reg;

  // Edge qualification, one-cycle event pulse
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      prev_reg <= 1'b0;
      event_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= pol_level;
      unique case (edge_select_in)
        CCEI_EDGE_NONE: event_reg <= 1'b0;
        CCEI_EDGE_RISE: event_reg <= rise;
        CCEI_EDGE_FALL: event_reg <= fall;
        CCEI_EDGE_ANY: event_reg <= rise | fall;
      endcase
    end
  end

  assign level_out = pol_level;
  assign event_out = event_reg;

endmodule // ccei_edge_detect

// [ccei_checker.sv]
// Port assertions of the comparator control block
`timescale 1ns/1ps
module ccei_checker
  import ccei_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [CCEI_ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic analog_result_in,
  input wire logic analog_enable_out,
  input wire logic positive_input_select_out,
  input wire logic [1:0] negative_input_select_out,
  input wire logic compare_out_pin_out,
  input wire logic compare_out_pin_oe_out,
  input wire logic irq_event_out,
  input wire logic irq_out
);
  wire ctl_wr = wr_in && addr_in == CCEI_CTRL_ADDR;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  property p_idle; !$past(rd_in) |-> rdata_out == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle read data");
  property p_resv; $past(rd_in) && $past(addr_in) == CCEI_CTRL_ADDR
    |-> (rdata_out & 32'hFFFF1E2C) == 32'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_en; ctl_wr |=> analog_enable_out == $past(wdata_in[15]); endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_pos; ctl_wr |=> positive_input_select_out == $past(wdata_in[4]); endproperty
  a_pos: assert property (p_pos) else $error("positive select wrong");
  property p_neg; ctl_wr |=> negative_input_select_out == $past(wdata_in[1:0]); endproperty
  a_neg: assert property (p_neg) else $error("negative select wrong");
  property p_oe; ctl_wr |-> ##2 compare_out_pin_oe_out == $past(wdata_in[14], 2); endproperty
  a_oe: assert property (p_oe) else $error("pin drive wrong");
  property p_rst; $rose(nrst_in) |-> negative_input_select_out == 2'h3; endproperty
  a_rst: assert property (p_rst) else $error("reset select wrong");
  property p_pulse; irq_event_out |=> !irq_event_out; endproperty
  a_pulse: assert property (p_pulse) else $error("event too long");
endmodule // ccei_checker
bind ccei_top ccei_checker u_ccei_checker (.clock_in(clock_in), .nrst_in(nrst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .analog_result_in(analog_result_in),
  .analog_enable_out(analog_enable_out), .irq_out(irq_out),
  .positive_input_select_out(positive_input_select_out),
  .negative_input_select_out(negative_input_select_out),
  .compare_out_pin_out(compare_out_pin_out), .irq_event_out(irq_event_out),
  .compare_out_pin_oe_out(compare_out_pin_oe_out));

// [ccei_analog_model.sv]
// Comparator core with nibble levels a, b, c, d, bandgap, ladder
`timescale 1ns/1ps
module ccei_analog_model
(
  input wire logic on_in,
  input wire logic pos_in,
  input wire logic [1:0] neg_in,
  input wire logic [23:0] lvl_in,
  output logic res_out
);
  logic [3:0] p, n;
  assign p = pos_in ? lvl_in[23:20] : lvl_in[3:0];
  assign n = lvl_in[{neg_in, 2'h0} + 5'h4 +: 4];
  assign res_out = on_in & (p > n);
endmodule // ccei_analog_model

// [testbench.sv]
// Self-checking bench of the comparator control block
`timescale 1ns/1ps
module testbench;
  import ccei_pkg::*;
  logic clock_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [7:0] addr_in = 8'h0;
  logic [31:0] wdata_in = 32'h0, rdata_out, w, r;
  logic [23:0] lvl = 24'h0;
  logic res, oe, pin, en, pos, ev, irq;
  logic [1:0] neg;
  int mismatches = 0, tests_run = 0, evs = 0, seed = 39633;
  always #4 clock_in = ~clock_in;
  always @(posedge clock_in) evs += (ev === 1'b1);
  ccei_top u_ccei_top (.clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .analog_result_in(res), .analog_enable_out(en), .positive_input_select_out(pos),
    .negative_input_select_out(neg), .compare_out_pin_out(pin),
    .compare_out_pin_oe_out(oe), .irq_event_out(ev), .irq_out(irq));
  ccei_analog_model u_ccei_analog_model (.on_in(en), .pos_in(pos), .neg_in(neg),
    .lvl_in(lvl), .res_out(res));
  ////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    r = rdata_out;
  endtask
  function logic res_of(input logic [31:0] c);
    return ((c[4] ? lvl[23:20] : lvl[3:0]) > lvl[4 * c[1:0] + 4 +: 4]) ^ c[13];
  endfunction
  function logic ev_of(input logic [1:0] s, input logic inv, input logic rise);
    return rise ^ inv ? s[0] : s[1];
  endfunction
  task test_done;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    test_done;
  end
  initial
  begin
    repeat (3) @(posedge clock_in);
    nrst_in <= 1'b1;
    rd(CCEI_CTRL_ADDR);
    chk(r, 32'h000000C3);
    rd(8'h0C);
    chk(r, 32'h0);
    for (int i = 0; i < 40; i++)
    begin
      w = $random(seed) | 32'h8000;
      lvl <= 24'($random(seed));
      wr(CCEI_CTRL_ADDR, w);
      repeat (6) @(posedge clock_in);
      rd(CCEI_CTRL_ADDR);
      chk(r, w & 32'hE0D3 | {23'h0, res_of(w), 8'h0});
      chk({26'h0, en, pos, neg, oe, pin}, {26'h0, 1'b1, w[4], w[1:0], w[14], w[14] & res_of(w)});
    end
    wr(CCEI_IRQ_MASK_ADDR, 32'h1);
    for (int k = 0; k < 8; k++)
    begin
      lvl <= 24'h0;
      w = {16'h0, 2'h3, k[2], 5'h0, k[1:0], 6'h0};
      wr(CCEI_CTRL_ADDR, w);
      repeat (8) @(posedge clock_in);
      wr(CCEI_IRQ_STATUS_ADDR, 32'h1);
      @(negedge clock_in);
      evs = 0;
      lvl <= 24'h1;
      repeat (8) @(posedge clock_in);
      chk(evs, {31'h0, ev_of(k[1:0], k[2], 1'b1)});
      rd(CCEI_IRQ_STATUS_ADDR);
      chk({r[0], irq}, {2{ev_of(k[1:0], k[2], 1'b1)}});
      evs = 0;
      lvl <= 24'h0;
      repeat (8) @(posedge clock_in);
      chk(evs, {31'h0, ev_of(k[1:0], k[2], 1'b0)});
    end
    test_done;
  end
endmodule // testbench
